//--- rtl/atf_pkg.sv
/*
 * Constants, register selects, field positions, opcode table and carrier
 * structs for the device-side task file block.
 * Assumes a host-side interface that turns link frames into register
 * selects with one-cycle read and write strobes, and a device back end
 * that runs the commands.
 */
// Summary of operation
// - Drive/head bits 7 and 5 always read as one, whatever is written.
// - Drive/head bit 6 chooses block addressing (1) or cylinder/head/sector (0).
// - Block address: sector, cylinder low, cylinder high, then drive/head low nibble.
// - Primary status read clears pending interrupt; auxiliary status read does not.
// - Status bit 7 shows device owns registers; other bits then invalid.
// - Status bit 6 stays clear from power-up until the device accepts commands.
// - Status bit 5 flags write fault; bit 4 is set whenever ready.
// - Status bit 3 is set while a data word must move.
// - Status bit 2 flags a corrected error without ending multi-sector reads.
// - Status bit 1 always reads zero.
// - Status bit 0 flags an errored command; error register holds cause.
// - Control bit 7 selects previous register values; command-block writes clear it.
// - Control bit 2 holds the device in soft reset while set.
// - Control bit 1 suppresses interrupts when one; zero after power-on.
// - Control bits 3, 0 ignored and bits 6 to 4 have no effect.
// - Drive address bit 6 reads zero while a write is in progress.
// - Drive address bits 5 to 2 are inverted drive/head bits 3 to 0.
// - Drive address bit 0 reads zero when drive 0 is selected; bit 1 always reads one.
// - Command decoder accepts the whole supported opcode set.
// - SMART feature value decodes as subcommand; reserved values are rejected.
// - Invalid or unrunnable commands abort with error bit 2 and status error.
package atf_pkg;
    // Command block selects.
    localparam logic [2:0] ATF_CB_DATA        = 3'h0;
    localparam logic [2:0] ATF_CB_ERR_FEAT    = 3'h1;
    localparam logic [2:0] ATF_CB_COUNT       = 3'h2;
    localparam logic [2:0] ATF_CB_SECTOR      = 3'h3;
    localparam logic [2:0] ATF_CB_CYL_LO      = 3'h4;
    localparam logic [2:0] ATF_CB_CYL_HI      = 3'h5;
    localparam logic [2:0] ATF_CB_DRIVE_HEAD  = 3'h6;
    localparam logic [2:0] ATF_CB_STATUS_CMD  = 3'h7;
    // Control block selects.
    localparam logic [2:0] ATF_CTL_AUX_STATUS = 3'h6;
    localparam logic [2:0] ATF_CTL_DRIVE_ADDR = 3'h7;
    // Drive/head fields.
    localparam int ATF_DH_LBA   = 6;
    localparam int ATF_DH_DRIVE = 4;
    localparam logic [7:0] ATF_DH_FORCED_ONES = 8'hA0;
    localparam logic [7:0] ATF_DH_RESET       = 8'hA0;
    // Status fields.
    localparam int ATF_ST_BUSY  = 7;
    localparam int ATF_ST_RDY   = 6;
    localparam int ATF_ST_WF    = 5;
    localparam int ATF_ST_SEEK  = 4;
    localparam int ATF_ST_DRQ   = 3;
    localparam int ATF_ST_CORRECTED_ERROR_FLAG  = 2;
    localparam int ATF_ST_INDEX = 1;
    localparam int ATF_ST_ERR   = 0;
    // Host control fields.
    localparam int ATF_HC_HOB   = 7;
    localparam int ATF_HC_SRST  = 2;
    localparam int ATF_HC_NIEN  = 1;
    localparam logic [7:0] ATF_HC_RESET = 8'h00;
    // Legacy drive address fields.
    localparam int ATF_DA_WTG_N = 6;
    localparam int ATF_DA_DS1_N = 1;
    localparam int ATF_DA_DS0_N = 0;
    // Error register abort bit.
    localparam int ATF_ER_ABORT = 2;
    // SMART opcode and subcommands.
    localparam logic [7:0] ATF_OP_SMART        = 8'hB0;
    localparam logic [7:0] ATF_SMART_DATA_LO   = 8'hD0;
    localparam logic [7:0] ATF_SMART_DATA_HI   = 8'hD4;
    localparam logic [7:0] ATF_SMART_ENABLE    = 8'hD8;
    localparam logic [7:0] ATF_SMART_STATUS    = 8'hDA;
    // Supported opcode table.
    localparam int ATF_NUM_OPCODES = 53;
    localparam logic [7:0] ATF_OPCODES [ATF_NUM_OPCODES] = '{
        8'hE5, 8'h98, 8'h06, 8'h90, 8'hE7, 8'hEA, 8'hEC, 8'hE3, 8'h97, 8'hE1,
        8'h95, 8'h91, 8'h00, 8'hE4, 8'hC8, 8'h25, 8'h60, 8'hC4, 8'h29, 8'hF8,
        8'h27, 8'h20, 8'h21, 8'h24, 8'h40, 8'h41, 8'h42, 8'hF6, 8'hF3, 8'hF4,
        8'hF5, 8'hF1, 8'hF2, 8'h70, 8'hEF, 8'hF9, 8'h37, 8'hC6, 8'hE6, 8'h99,
        8'hB0, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE8, 8'hCA, 8'h35, 8'h61, 8'hC5,
        8'h39, 8'h30, 8'h34
    };

    // Host register access: one request per cycle at most.
    typedef struct packed {
        logic       ctl_sel;   // One selects the control block.
        logic [2:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } atf_host_req_s;

    // Back-end state reported to the task file.
    typedef struct packed {
        logic       ready;
        logic       done;
        logic       error;
        logic [7:0] err_code;
        logic       data_request_flag;
        logic       corrected_error_flag;
        logic       write_fault;
        logic       write_active;
    } atf_back_s;
endpackage

//--- rtl/atf_task_file.sv
/*
 * Device-side task file: shadow registers with previous-value readback,
 * drive/head select, status, host control, legacy drive address, opcode
 * and SMART subcommand decode, abort handling and the interrupt request.
 * Assumes host requests arrive synchronous to sys_clk_in and that the
 * back end pulses done once per accepted command.
 */
`timescale 1ns/1ps
`default_nettype none
module atf_task_file (
    input  wire logic                   sys_clk_in,
    input  wire logic                   nrst_in,
    input  wire atf_pkg::atf_host_req_s host_req_in,
    input  wire atf_pkg::atf_back_s     back_in,
    output logic [7:0]                  rdata_out,
    output logic                        rvalid_out,
    output logic                        intrq_out,
    output logic                        cmd_valid_out,
    output logic [7:0]                  cmd_opcode_out,
    output logic [7:0]                  cmd_feature_out,
    output logic [7:0]                  cmd_count_out,
    output logic                        lba_mode_out,
    output logic [27:0]                 block_addr_out,
    output logic                        soft_reset_out
);
    import atf_pkg::*;

    // Shadow registers, current and previously written values.
    logic [7:0] feature_reg, feature_next;
    logic [7:0] count_reg, count_next, count_prev_reg, count_prev_next;
    logic [7:0] sector_reg, sector_next, sector_prev_reg, sector_prev_next;
    logic [7:0] cyl_lo_reg, cyl_lo_next, cyl_lo_prev_reg, cyl_lo_prev_next;
    logic [7:0] cyl_hi_reg, cyl_hi_next, cyl_hi_prev_reg, cyl_hi_prev_next;
    logic [7:0] drive_head_select_reg, drive_head_select_next;
    logic [7:0] dh_prev_reg, dh_prev_next;
    logic [7:0] host_control_reg, host_control_next;
    logic [7:0] error_reg, error_next;
    // Status state.
    logic       busy_reg, busy_next;
    logic       ready_seen_reg, ready_seen_next;
    logic       err_flag_reg, err_flag_next;
    logic       corrected_error_flag_flag_reg, corrected_error_flag_flag_next;
    logic       pend_reg, pend_next;
    logic       drq_q_reg, drq_q_next;
    // Output registers.
    logic [7:0]  rdata_next;
    logic        rvalid_next, intrq_next, cmd_valid_next, lba_mode_next, soft_reset_next;
    logic [7:0]  cmd_opcode_next, cmd_feature_next, cmd_count_next;
    logic [27:0] block_addr_next;

    // True when the opcode appears in the supported table.
    function automatic logic opcode_known(input logic [7:0] op);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < ATF_NUM_OPCODES; i++) begin
            if (ATF_OPCODES[i] == op) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // True when a SMART feature value names a supported subcommand.
    function automatic logic smart_sub_known(input logic [7:0] sub);
        return ((sub >= ATF_SMART_DATA_LO) && (sub <= ATF_SMART_DATA_HI)) ||
               ((sub >= ATF_SMART_ENABLE) && (sub <= ATF_SMART_STATUS));
    endfunction

    // Picks current or previous shadow value by the readback select.
    function automatic logic [7:0] pick(input logic high_order_readback_select, input logic [7:0] cur,
                                        input logic [7:0] prev);
        return high_order_readback_select ? prev : cur;
    endfunction

    logic [7:0] status_now;
    logic [7:0] drive_addr_now;
    logic       wr_cb, rd_cb, wr_ctl, rd_ctl, srst, cmd_write, cmd_ok, drq_rise;

    // Status byte and legacy drive address assembly.
    always_comb begin
        status_now               = 8'h00;
        status_now[ATF_ST_BUSY]  = busy_reg;
        status_now[ATF_ST_RDY]   = ready_seen_reg;
        status_now[ATF_ST_WF]    = back_in.write_fault;
        status_now[ATF_ST_SEEK]  = ready_seen_reg;
        status_now[ATF_ST_DRQ]   = back_in.data_request_flag;
        status_now[ATF_ST_CORRECTED_ERROR_FLAG]  = corrected_error_flag_flag_reg;
        status_now[ATF_ST_INDEX] = 1'b0;
        status_now[ATF_ST_ERR]   = err_flag_reg;
        drive_addr_now                = 8'h00;
        drive_addr_now[ATF_DA_WTG_N]  = ~back_in.write_active;
        drive_addr_now[5:2]           = ~drive_head_select_reg[3:0];
        drive_addr_now[ATF_DA_DS1_N]  = 1'b1;
        drive_addr_now[ATF_DA_DS0_N]  = drive_head_select_reg[ATF_DH_DRIVE];
    end

    // Decoded strobes for this cycle.
    always_comb begin
        wr_cb     = host_req_in.wr && !host_req_in.ctl_sel;
        rd_cb     = host_req_in.rd && !host_req_in.ctl_sel;
        wr_ctl    = host_req_in.wr && host_req_in.ctl_sel;
        rd_ctl    = host_req_in.rd && host_req_in.ctl_sel;
        srst      = host_control_reg[ATF_HC_SRST];
        cmd_write = wr_cb && (host_req_in.addr == ATF_CB_STATUS_CMD) && !busy_reg && !srst;
        cmd_ok    = opcode_known(host_req_in.wdata) &&
                    ((host_req_in.wdata != ATF_OP_SMART) ||
                     smart_sub_known(feature_reg)) &&
                    ready_seen_reg && !back_in.write_fault;
        drq_rise  = back_in.data_request_flag && !drq_q_reg;
    end

    // Next-state logic for all task file state and the outputs.
    always_comb begin
        feature_next           = feature_reg;
        count_next             = count_reg;
        count_prev_next        = count_prev_reg;
        sector_next            = sector_reg;
        sector_prev_next       = sector_prev_reg;
        cyl_lo_next            = cyl_lo_reg;
        cyl_lo_prev_next       = cyl_lo_prev_reg;
        cyl_hi_next            = cyl_hi_reg;
        cyl_hi_prev_next       = cyl_hi_prev_reg;
        drive_head_select_next = drive_head_select_reg;
        dh_prev_next           = dh_prev_reg;
        host_control_next      = host_control_reg;
        error_next             = error_reg;
        busy_next              = busy_reg;
        ready_seen_next        = ready_seen_reg | back_in.ready;
        err_flag_next          = err_flag_reg;
        corrected_error_flag_flag_next         = corrected_error_flag_flag_reg | back_in.corrected_error_flag;
        pend_next              = pend_reg;
        drq_q_next             = back_in.data_request_flag;
        rdata_next             = rdata_out;
        rvalid_next            = host_req_in.rd;
        cmd_valid_next         = 1'b0;
        cmd_opcode_next        = cmd_opcode_out;
        cmd_feature_next       = cmd_feature_out;
        cmd_count_next         = cmd_count_out;
        lba_mode_next          = lba_mode_out;
        block_addr_next        = block_addr_out;
        soft_reset_next        = srst;

        // Register reads; the previous value is returned when selected.
        if (rd_cb) begin
            case (host_req_in.addr)
                ATF_CB_ERR_FEAT:   rdata_next = error_reg;
                ATF_CB_COUNT:      rdata_next = pick(host_control_reg[ATF_HC_HOB],
                                                     count_reg, count_prev_reg);
                ATF_CB_SECTOR:     rdata_next = pick(host_control_reg[ATF_HC_HOB],
                                                     sector_reg, sector_prev_reg);
                ATF_CB_CYL_LO:     rdata_next = pick(host_control_reg[ATF_HC_HOB],
                                                     cyl_lo_reg, cyl_lo_prev_reg);
                ATF_CB_CYL_HI:     rdata_next = pick(host_control_reg[ATF_HC_HOB],
                                                     cyl_hi_reg, cyl_hi_prev_reg);
                ATF_CB_DRIVE_HEAD: rdata_next = pick(host_control_reg[ATF_HC_HOB],
                                                     drive_head_select_reg, dh_prev_reg);
                ATF_CB_STATUS_CMD: rdata_next = status_now;
                default:           rdata_next = 8'h00;
            endcase
        end else if (rd_ctl) begin
            case (host_req_in.addr)
                ATF_CTL_AUX_STATUS: rdata_next = status_now;
                ATF_CTL_DRIVE_ADDR: rdata_next = drive_addr_now;
                default:            rdata_next = 8'h00;
            endcase
        end

        // Primary status read drops the pending interrupt.
        if (rd_cb && (host_req_in.addr == ATF_CB_STATUS_CMD)) begin
            pend_next = 1'b0;
        end

        // Command block writes are locked out while busy.
        if (wr_cb && !busy_reg && !srst) begin
            host_control_next[ATF_HC_HOB] = 1'b0;
            case (host_req_in.addr)
                ATF_CB_ERR_FEAT: feature_next = host_req_in.wdata;
                ATF_CB_COUNT: begin
                    count_prev_next = count_reg;
                    count_next      = host_req_in.wdata;
                end
                ATF_CB_SECTOR: begin
                    sector_prev_next = sector_reg;
                    sector_next      = host_req_in.wdata;
                end
                ATF_CB_CYL_LO: begin
                    cyl_lo_prev_next = cyl_lo_reg;
                    cyl_lo_next      = host_req_in.wdata;
                end
                ATF_CB_CYL_HI: begin
                    cyl_hi_prev_next = cyl_hi_reg;
                    cyl_hi_next      = host_req_in.wdata;
                end
                ATF_CB_DRIVE_HEAD: begin
                    dh_prev_next           = drive_head_select_reg;
                    drive_head_select_next = host_req_in.wdata | ATF_DH_FORCED_ONES;
                end
                default: begin
                end
            endcase
        end

        // Host control write; only the readback, reset and enable bits act.
        if (wr_ctl && (host_req_in.addr == ATF_CTL_AUX_STATUS)) begin
            host_control_next = 8'h00;
            host_control_next[ATF_HC_HOB]  = host_req_in.wdata[ATF_HC_HOB];
            host_control_next[ATF_HC_SRST] = host_req_in.wdata[ATF_HC_SRST];
            host_control_next[ATF_HC_NIEN] = host_req_in.wdata[ATF_HC_NIEN];
        end

        // Command issue: accept and hand to the back end, or abort at once.
        if (cmd_write) begin
            corrected_error_flag_flag_next = back_in.corrected_error_flag;
            if (cmd_ok) begin
                busy_next        = 1'b1;
                err_flag_next    = 1'b0;
                error_next       = 8'h00;
                cmd_valid_next   = 1'b1;
                cmd_opcode_next  = host_req_in.wdata;
                cmd_feature_next = feature_reg;
                cmd_count_next   = count_reg;
                lba_mode_next    = drive_head_select_reg[ATF_DH_LBA];
                block_addr_next  = {drive_head_select_reg[3:0], cyl_hi_reg,
                                    cyl_lo_reg, sector_reg};
            end else begin
                error_next               = 8'h00;
                error_next[ATF_ER_ABORT] = 1'b1;
                err_flag_next            = 1'b1;
                pend_next                = 1'b1;
            end
        end

        // Back-end completion ends busy and reports any error cause.
        if (back_in.done && busy_reg) begin
            busy_next = 1'b0;
            pend_next = 1'b1;
            if (back_in.error) begin
                err_flag_next = 1'b1;
                error_next    = back_in.err_code;
            end
        end
        if (drq_rise) begin
            pend_next = 1'b1;
        end

        // Soft reset holds the block busy and clears command state.
        if (srst) begin
            busy_next      = 1'b1;
            err_flag_next  = 1'b0;
            corrected_error_flag_flag_next = 1'b0;
            pend_next      = 1'b0;
            error_next     = 8'h00;
            drive_head_select_next = ATF_DH_RESET;
        end else if (soft_reset_out) begin
            busy_next = 1'b0;
        end

        intrq_next = pend_next && !host_control_next[ATF_HC_NIEN];
    end

    // Register stage for all state and outputs.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            feature_reg           <= 8'h00;
            count_reg             <= 8'h00;
            count_prev_reg        <= 8'h00;
            sector_reg            <= 8'h00;
            sector_prev_reg       <= 8'h00;
            cyl_lo_reg            <= 8'h00;
            cyl_lo_prev_reg       <= 8'h00;
            cyl_hi_reg            <= 8'h00;
            cyl_hi_prev_reg       <= 8'h00;
            drive_head_select_reg <= ATF_DH_RESET;
            dh_prev_reg           <= ATF_DH_RESET;
            host_control_reg      <= ATF_HC_RESET;
            error_reg             <= 8'h00;
            busy_reg              <= 1'b0;
            ready_seen_reg        <= 1'b0;
            err_flag_reg          <= 1'b0;
            corrected_error_flag_flag_reg         <= 1'b0;
            pend_reg              <= 1'b0;
            drq_q_reg             <= 1'b0;
            rdata_out             <= 8'h00;
            rvalid_out            <= 1'b0;
            intrq_out             <= 1'b0;
            cmd_valid_out         <= 1'b0;
            cmd_opcode_out        <= 8'h00;
            cmd_feature_out       <= 8'h00;
            cmd_count_out         <= 8'h00;
            lba_mode_out          <= 1'b0;
            block_addr_out        <= 28'h000_0000;
            soft_reset_out        <= 1'b0;
        end else begin
            feature_reg           <= feature_next;
            count_reg             <= count_next;
            count_prev_reg        <= count_prev_next;
            sector_reg            <= sector_next;
            sector_prev_reg       <= sector_prev_next;
            cyl_lo_reg            <= cyl_lo_next;
            cyl_lo_prev_reg       <= cyl_lo_prev_next;
            cyl_hi_reg            <= cyl_hi_next;
            cyl_hi_prev_reg       <= cyl_hi_prev_next;
            drive_head_select_reg <= drive_head_select_next;
            dh_prev_reg           <= dh_prev_next;
            host_control_reg      <= host_control_next;
            error_reg             <= error_next;
            busy_reg              <= busy_next;
            ready_seen_reg        <= ready_seen_next;
            err_flag_reg          <= err_flag_next;
            corrected_error_flag_flag_reg         <= corrected_error_flag_flag_next;
            pend_reg              <= pend_next;
            drq_q_reg             <= drq_q_next;
            rdata_out             <= rdata_next;
            rvalid_out            <= rvalid_next;
            intrq_out             <= intrq_next;
            cmd_valid_out         <= cmd_valid_next;
            cmd_opcode_out        <= cmd_opcode_next;
            cmd_feature_out       <= cmd_feature_next;
            cmd_count_out         <= cmd_count_next;
            lba_mode_out          <= lba_mode_next;
            block_addr_out        <= block_addr_next;
            soft_reset_out        <= soft_reset_next;
        end
    end
endmodule
`default_nettype wire

//--- sim/atf_task_file_assertions.sv
/* Port checks for the task file.
   Bound to atf_task_file from tb_top; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module atf_task_file_assertions (
    input wire logic                   sys_clk_in,
    input wire logic                   nrst_in,
    input wire atf_pkg::atf_host_req_s host_req_in,
    input wire atf_pkg::atf_back_s     back_in,
    input wire logic                   rvalid_out,
    input wire logic                   intrq_out,
    input wire logic                   cmd_valid_out,
    input wire logic [7:0]             cmd_opcode_out,
    input wire logic [7:0]             cmd_feature_out,
    input wire logic                   soft_reset_out
);
    import atf_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // Decoded host strobes used by several properties.
    wire logic cmd_wr = host_req_in.wr && !host_req_in.ctl_sel && host_req_in.addr == 3'h7;
    wire logic hc_wr = host_req_in.wr && host_req_in.ctl_sel && host_req_in.addr == 3'h6;
    wire logic srst_bit = host_req_in.wdata[ATF_HC_SRST];
    wire logic wdat7 = host_req_in.wdata[7];
    sequence s_status_read;
        host_req_in.rd && !host_req_in.ctl_sel && host_req_in.addr == 3'h7;
    endsequence
    a_read_answers: assert property (host_req_in.rd |=> rvalid_out)
        else $error("read not answered");
    a_status_clears_irq: assert property (s_status_read ##0 !back_in.done && !back_in.data_request_flag
        |=> !intrq_out) else $error("status read left interrupt up");
    a_aux_keeps_irq: assert property (host_req_in.rd && host_req_in.ctl_sel &&
        host_req_in.addr == 3'h6 && intrq_out && !soft_reset_out &&
        !$past(hc_wr && srst_bit) |=> intrq_out) else $error("aux read dropped interrupt");
    a_cmd_from_write: assert property (cmd_valid_out |-> $past(cmd_wr))
        else $error("command without write");
    a_opcode_taken: assert property (cmd_valid_out |->
        cmd_opcode_out == $past(host_req_in.wdata)) else $error("opcode differs from write");
    a_opcode_held: assert property (!cmd_valid_out && !soft_reset_out |->
        $stable(cmd_opcode_out)) else $error("opcode moved");
    a_smart_legal: assert property (cmd_valid_out && cmd_opcode_out == ATF_OP_SMART |->
        cmd_feature_out inside {[ATF_SMART_DATA_LO:ATF_SMART_DATA_HI],
        [ATF_SMART_ENABLE:ATF_SMART_STATUS]}) else $error("bad smart feature accepted");
    a_srst_follows: assert property (hc_wr |=> ##1 soft_reset_out == $past(srst_bit, 2))
        else $error("soft reset not copied");
    a_srst_blocks_cmd: assert property (soft_reset_out |=> !cmd_valid_out)
        else $error("command in soft reset");
endmodule
`default_nettype wire

//--- sim/atf_back_model.sv
/* Back end stand-in: ready on request, one done pulse per command.
   Runs on the task file clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module atf_back_model #(parameter int DELAY = 4) (
    input  wire logic              sys_clk_in,
    input  wire logic              nrst_in,
    input  wire logic              ready_in,
    input  wire logic              cmd_valid_in,
    output var atf_pkg::atf_back_s back_out
);
    import atf_pkg::*;
    int cnt = 0;
    // Counts each accepted command down to its done pulse.
    always @(posedge sys_clk_in) begin
        back_out <= '0;
        back_out.ready <= ready_in && nrst_in;
        cnt <= cmd_valid_in ? DELAY : (cnt > 0 ? cnt - 1 : 0);
        back_out.done <= (cnt == 1);
        back_out.write_active <= cnt > 0;
    end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
/* Bench for the task file: register rows, commands, aborts, interrupts.
   Uses atf_back_model as the back end. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import atf_pkg::*;
    typedef struct {logic [7:0] wd, dh, da;} atf_row_s;
    logic sys_clk, nrst, rdy_en, rv, irq, cv, lba, srst;
    logic [7:0] rd_data, op, feat, v;
    logic [27:0] ba;
    atf_host_req_s req;
    atf_back_s back;
    int n_errors, checks_done;
    atf_row_s rows [3] = '{'{8'h0F, 8'hAF, 8'h42}, '{8'h03, 8'hA3, 8'h72}, '{8'h45, 8'hE5, 8'h6A}};
    logic [7:0] feats [2] = '{8'hD5, 8'hDA};
    atf_task_file i_dut (.sys_clk_in(sys_clk), .nrst_in(nrst), .host_req_in(req),
        .back_in(back), .rdata_out(rd_data), .rvalid_out(rv), .intrq_out(irq),
        .cmd_valid_out(cv), .cmd_opcode_out(op), .cmd_feature_out(feat), .cmd_count_out(),
        .lba_mode_out(lba), .block_addr_out(ba), .soft_reset_out(srst));
    atf_back_model i_back (.sys_clk_in(sys_clk), .nrst_in(nrst), .ready_in(rdy_en),
        .cmd_valid_in(cv), .back_out(back));
    task automatic chk(string n, logic [27:0] s, logic [27:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic c, logic [2:0] a, logic [7:0] d);
        @(posedge sys_clk) req <= '{c, a, 1'b1, 1'b0, d};
        @(posedge sys_clk) req <= '0;
    endtask
    task automatic rd(logic c, logic [2:0] a);
        @(posedge sys_clk) req <= '{c, a, 1'b0, 1'b1, 8'h00};
        @(posedge sys_clk) req <= '0;
        #1 v = rd_data;
    endtask
    task automatic results;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // The run needs about 130 cycles; ten thousand means a hang.
    initial begin
        #100_000 n_errors++;
        results;
    end
    initial begin
        nrst = 0; rdy_en = 0; req = '0; n_errors = 0; checks_done = 0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1;
        rd(0, ATF_CB_STATUS_CMD);
        chk("status early", v, 8'h00);
        rdy_en = 1;
        foreach (rows[i]) begin
            wr(0, ATF_CB_DRIVE_HEAD, rows[i].wd);
            rd(0, ATF_CB_DRIVE_HEAD);
            chk("drive head", v, rows[i].dh);
            rd(1, ATF_CTL_DRIVE_ADDR);
            chk("drive addr", v, rows[i].da);
        end
        rd(0, ATF_CB_STATUS_CMD);
        chk("status ready", v, 8'h50);
        wr(0, ATF_CB_COUNT, 8'h12);
        wr(0, ATF_CB_COUNT, 8'h34);
        wr(1, ATF_CTL_AUX_STATUS, 8'h80);
        rd(0, ATF_CB_COUNT);
        chk("previous count", v, 8'h12);
        wr(0, ATF_CB_SECTOR, 8'h11);
        rd(0, ATF_CB_COUNT);
        chk("latest count", v, 8'h34);
        wr(0, ATF_CB_CYL_LO, 8'h22);
        wr(0, ATF_CB_CYL_HI, 8'h33);
        wr(0, ATF_CB_STATUS_CMD, 8'hCA);
        #1 chk("lba mode", lba, 1'b1);
        chk("block addr", ba, 28'h533_2211);
        rd(0, ATF_CB_STATUS_CMD);
        chk("busy", v[7], 1'b1);
        rd(1, ATF_CTL_DRIVE_ADDR);
        chk("writing", v, 8'h2A);
        repeat (10) @(posedge sys_clk);
        rd(1, ATF_CTL_AUX_STATUS);
        chk("aux irq", irq, 1'b1);
        rd(0, ATF_CB_STATUS_CMD);
        chk("irq cleared", irq, 1'b0);
        wr(0, ATF_CB_STATUS_CMD, 8'h01);
        rd(0, ATF_CB_ERR_FEAT);
        chk("abort code", v, 8'h04);
        rd(0, ATF_CB_STATUS_CMD);
        chk("status error", v, 8'h51);
        foreach (feats[i]) begin
            wr(0, ATF_CB_ERR_FEAT, feats[i]);
            wr(0, ATF_CB_STATUS_CMD, ATF_OP_SMART);
            #1 chk("smart accept", cv, feats[i] == 8'hDA);
            repeat (10) @(posedge sys_clk);
        end
        wr(1, ATF_CTL_AUX_STATUS, 8'h04);
        @(posedge sys_clk);
        #1 chk("soft reset", srst, 1'b1);
        wr(1, ATF_CTL_AUX_STATUS, 8'h02);
        repeat (3) @(posedge sys_clk);
        rd(0, ATF_CB_STATUS_CMD);
        chk("after reset", v, 8'h50);
        wr(0, ATF_CB_STATUS_CMD, 8'hEF);
        repeat (10) @(posedge sys_clk);
        #1 chk("masked irq", irq, 1'b0);
        results;
    end
endmodule
bind atf_task_file atf_task_file_assertions i_chk (.sys_clk_in, .nrst_in, .host_req_in,
    .back_in, .rvalid_out, .intrq_out, .cmd_valid_out, .cmd_opcode_out, .cmd_feature_out,
    .soft_reset_out);
`default_nettype wire
